// >>> src/hcc_chop_if.sv
// Signals between the bridge control and one regulation channel
`default_nettype none

interface hcc_chop_if;
  logic        en;
  logic        trip;
  logic        drive_req;
  logic [11:0] off_cyc;
  logic [11:0] blank_cyc;
  logic        regulating;

  modport ctl  (output en, trip, drive_req, off_cyc, blank_cyc,
                input  regulating);
  modport chop (input  en, trip, drive_req, off_cyc, blank_cyc,
                output regulating);
endinterface

`default_nettype wire

// >>> src/hcc_chopper.sv
// Blanking and fixed off-time regulation for one half-bridge
`default_nettype none

module hcc_chopper
  import hcc_pkg::*;
(
  input  wire logic clk_i,    // System clock
  input  wire logic rst_n_i,  // Synchronous reset, active low
  hcc_chop_if.chop  cif       // Channel signals
);
  hcc_chop_t   st_q;
  logic [11:0] cnt_q;

  assign cif.regulating = (st_q == CH_OFF);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !cif.en) begin
      st_q  <= CH_IDLE;
      cnt_q <= 12'h000;
    end else begin
      unique case (st_q)
        CH_IDLE: begin
          if (cif.drive_req) begin
            st_q  <= CH_BLANK;
            cnt_q <= cif.blank_cyc;
          end
        end
        CH_BLANK: begin
          if (!cif.drive_req) begin
            st_q <= CH_IDLE;
          end else if (cnt_q <= 12'h001) begin
            st_q <= CH_ARMED;
          end else begin
            cnt_q <= cnt_q - 12'h001;
          end
        end
        CH_ARMED: begin
          if (cif.trip) begin
            st_q  <= CH_OFF;
            cnt_q <= cif.off_cyc;
          end else if (!cif.drive_req) begin
            st_q <= CH_IDLE;
          end
        end
        CH_OFF: begin
          if (cnt_q > 12'h001) begin
            cnt_q <= cnt_q - 12'h001;
          end else if (cif.trip) begin
            cnt_q <= cif.off_cyc;
          end else if (cif.drive_req) begin
            st_q  <= CH_BLANK;
            cnt_q <= cif.blank_cyc;
          end else begin
            st_q <= CH_IDLE;
          end
        end
      endcase
    end
  end
endmodule

`default_nettype wire

// >>> src/hcc_deglitch.sv
// Two-stage synchroniser followed by a stable-time noise filter
`default_nettype none

module hcc_deglitch #(
  parameter int unsigned DG_CYC = 25
) (
  input  wire logic clk_i,    // System clock
  input  wire logic rst_n_i,  // Synchronous reset, active low
  input  wire logic raw_i,    // Asynchronous input
  output logic      clean_o   // Filtered level
);
  logic       s1_q;
  logic       s2_q;
  logic [7:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= raw_i;
      s2_q <= s1_q;
    end
  end

  // A new level must hold DG_CYC cycles before it is passed on
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q   <= 8'h00;
      clean_o <= 1'b0;
    end else if (s2_q == clean_o) begin
      cnt_q <= 8'h00;
    end else if (cnt_q == 8'(DG_CYC - 1)) begin
      cnt_q   <= 8'h00;
      clean_o <= s2_q;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

`default_nettype wire

// >>> src/hcc_params.svh
// Constants of the H-bridge current chopper: offsets, fields, resets, timing
`ifndef HCC_PARAMS_SVH
`define HCC_PARAMS_SVH

// ============================================================
// Register offsets (byte addresses)
`define HCC_REG_CTRL        8'h00
`define HCC_REG_STAT        8'h04

// ============================================================
// Control register fields
`define HCC_CTRL_OFF_TIME_SELECT_LSB   0
`define HCC_CTRL_TLVL_LSB   2
`define HCC_CTRL_MASK_LSB   4
`define HCC_CTRL_SLEW_LSB   6

// ============================================================
// Status register fields
`define HCC_STAT_REG_LSB    0
`define HCC_STAT_PIN_LSB    2
`define HCC_STAT_MASK_LSB   3
`define HCC_STAT_SLEW_LSB   5
`define HCC_STAT_TLVL_LSB   8
`define HCC_STAT_IN_LSB     10

// ============================================================
// Reset values and fixed settings of the strapped variant
`define HCC_OFF_TIME_SELECT_RST        2'h1
`define HCC_TLVL_RST        2'h0
`define HCC_MASK_RST        2'h0
`define HCC_SLEW_RST        3'h0
`define HCC_PIN_TLVL        2'h2
`define HCC_PIN_OFF_TIME_SELECT        2'h1
`define HCC_SLEW_FAST       3'h0
`define HCC_SLEW_MID        3'h3
`define HCC_SLEW_SLOW       3'h7
`define HCC_STRAP_GND       2'h0
`define HCC_STRAP_HIGH      2'h3

// ============================================================
// Timing
`define HCC_CLK_MHZ         25
`define HCC_OFF_TIME_SELECT_STEP_US    20
`define HCC_OFF_TIME_SELECT_STEP_CYC   (`HCC_OFF_TIME_SELECT_STEP_US * `HCC_CLK_MHZ)
`define HCC_BLANK_NS        4000
`define HCC_BLANK_CYC       ((`HCC_BLANK_NS * `HCC_CLK_MHZ + 999) / 1000)
`define HCC_DEAD_BASE_NS    200
`define HCC_DEAD_BASE_CYC   ((`HCC_DEAD_BASE_NS * `HCC_CLK_MHZ + 999) / 1000)
`define HCC_DEAD_STEP_NS    100
`define HCC_DEAD_STEP_CYC   ((`HCC_DEAD_STEP_NS * `HCC_CLK_MHZ + 999) / 1000)
`define HCC_DGL_NS          1000
`define HCC_DGL_CYC         ((`HCC_DGL_NS * `HCC_CLK_MHZ + 999) / 1000)
`define HCC_TRIP_FLT_CYC    2
`define HCC_STRAP_SETTLE    3

`endif

// >>> src/hcc_pkg.sv
// Types shared by the H-bridge current chopper modules
`default_nettype none

package hcc_pkg;
  // Drive state of one half-bridge
  typedef enum logic [1:0] {HB_OFF, HB_HI, HB_LO} hcc_hb_t;
  // Regulation state of one half-bridge
  typedef enum logic [1:0] {CH_IDLE, CH_BLANK, CH_ARMED, CH_OFF} hcc_chop_t;
endpackage

`default_nettype wire

// >>> src/hcc_top.sv
// H-bridge fixed off-time current chopper with slew and dead-time control
//
// Added by the designer: the register offsets and the strobed register port.
`include "hcc_params.svh"
`default_nettype none

module hcc_top
  import hcc_pkg::*;
(
  input  wire logic        REF_CLK_I,        // 25 MHz clock
  input  wire logic        RST_N_I,          // Sync reset, active low
  input  wire logic [7:0]  REG_ADDR_I,       // Register byte address
  input  wire logic [31:0] REG_WDATA_I,      // Write data
  input  wire logic        REG_WR_I,         // Write strobe
  input  wire logic        REG_RD_I,         // Read strobe
  output logic      [31:0] REG_RDATA_O,      // Read data, cycle after
  input  wire logic [1:0]  BRIDGE_IN_I,      // Controller inputs 1 and 2
  input  wire logic [1:0]  OVER_TRIP_I,      // Per-output over-threshold
  input  wire logic        VARIANT_PIN_I,    // High: strapped variant
  input  wire logic        REGULATION_DISABLE_STRAP_I, // Strap, high off
  input  wire logic [1:0]  SLEW_STRAP_I,     // Sensed slew strap level
  output logic      [1:0]  HS_ON_O,          // High-side switch enables
  output logic      [1:0]  LS_ON_O,          // Low-side switch enables
  output logic      [1:0]  TRIP_LEVEL_SELECT_O, // Threshold to sensing
  output logic      [2:0]  SLEW_SELECT_O,    // Gate ramp setting
  output logic      [1:0]  REGULATING_O      // Off period active
);
  // ============================================================
  // Declarations
  logic [1:0]  off_time_select_q;
  logic [1:0]  tlvl_q;
  logic [1:0]  mask_q;
  logic [2:0]  slew_q;
  logic [3:0]  strap_s1_q;
  logic [3:0]  strap_s2_q;
  logic [1:0]  settle_q;
  logic        pin_var_q;
  logic        dis_strap_q;
  logic [1:0]  slew_strap_q;
  logic [1:0]  in_cln;
  logic [1:0]  trip_cln;
  logic [1:0]  off_time_select_eff;
  logic [1:0]  tlvl_eff;
  logic [1:0]  mask_eff;
  logic [2:0]  slew_eff;
  logic [2:0]  slew_pin;
  logic [11:0] off_cyc;
  logic [11:0] dead_cyc;
  logic [1:0]  reg_act;
  logic [1:0]  fwd_q;
  logic        reverse;
  logic        force_hi;
  logic [1:0]  cmd_hi;
  hcc_hb_t     tgt [2];
  logic [31:0] rd_val;

  // ============================================================
  // Register port
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      off_time_select_q <= `HCC_OFF_TIME_SELECT_RST;
      tlvl_q <= `HCC_TLVL_RST;
      mask_q <= `HCC_MASK_RST;
      slew_q <= `HCC_SLEW_RST;
    end else if (REG_WR_I && REG_ADDR_I == `HCC_REG_CTRL) begin
      off_time_select_q <= REG_WDATA_I[`HCC_CTRL_OFF_TIME_SELECT_LSB +: 2];
      tlvl_q <= REG_WDATA_I[`HCC_CTRL_TLVL_LSB +: 2];
      mask_q <= REG_WDATA_I[`HCC_CTRL_MASK_LSB +: 2];
      slew_q <= REG_WDATA_I[`HCC_CTRL_SLEW_LSB +: 3];
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    if (REG_ADDR_I == `HCC_REG_CTRL) begin
      rd_val[`HCC_CTRL_OFF_TIME_SELECT_LSB +: 2] = off_time_select_q;
      rd_val[`HCC_CTRL_TLVL_LSB +: 2] = tlvl_q;
      rd_val[`HCC_CTRL_MASK_LSB +: 2] = mask_q;
      rd_val[`HCC_CTRL_SLEW_LSB +: 3] = slew_q;
    end else if (REG_ADDR_I == `HCC_REG_STAT) begin
      rd_val[`HCC_STAT_REG_LSB +: 2]  = reg_act;
      rd_val[`HCC_STAT_PIN_LSB]       = pin_var_q;
      rd_val[`HCC_STAT_MASK_LSB +: 2] = mask_eff;
      rd_val[`HCC_STAT_SLEW_LSB +: 3] = slew_eff;
      rd_val[`HCC_STAT_TLVL_LSB +: 2] = tlvl_eff;
      rd_val[`HCC_STAT_IN_LSB +: 2]   = in_cln;
    end
  end

  // Unmapped addresses and idle cycles read as zero
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O <= 32'h0000_0000;
    end else if (REG_RD_I) begin
      REG_RDATA_O <= rd_val;
    end else begin
      REG_RDATA_O <= 32'h0000_0000;
    end
  end

  // ============================================================
  // Strap capture
  // Straps are latched once after reset so that a strap that moves
  // later cannot change the variant in mid-operation.
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      strap_s1_q <= 4'h0;
      strap_s2_q <= 4'h0;
    end else begin
      strap_s1_q <= {VARIANT_PIN_I, REGULATION_DISABLE_STRAP_I,
                     SLEW_STRAP_I};
      strap_s2_q <= strap_s1_q;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      settle_q     <= 2'h0;
      pin_var_q    <= 1'b0;
      dis_strap_q  <= 1'b0;
      slew_strap_q <= `HCC_STRAP_GND;
    end else if (settle_q != 2'(`HCC_STRAP_SETTLE)) begin
      settle_q <= settle_q + 2'h1;
      if (settle_q == 2'(`HCC_STRAP_SETTLE - 1)) begin
        pin_var_q    <= strap_s2_q[3];
        dis_strap_q  <= strap_s2_q[2];
        slew_strap_q <= strap_s2_q[1:0];
      end
    end
  end

  // ============================================================
  // Effective configuration
  // slew strap decode
  always_comb begin
    if (slew_strap_q == `HCC_STRAP_GND) begin
      slew_pin = `HCC_SLEW_FAST;
    end else if (slew_strap_q == `HCC_STRAP_HIGH) begin
      slew_pin = `HCC_SLEW_SLOW;
    end else begin
      slew_pin = `HCC_SLEW_MID;
    end
  end

  assign tlvl_eff = pin_var_q ? `HCC_PIN_TLVL : tlvl_q;
  assign off_time_select_eff = pin_var_q ? `HCC_PIN_OFF_TIME_SELECT : off_time_select_q;
  assign mask_eff = pin_var_q ? {2{dis_strap_q}} : mask_q;
  assign slew_eff = pin_var_q ? slew_pin : slew_q;

  assign off_cyc = 12'((32'(off_time_select_eff) + 1) * `HCC_OFF_TIME_SELECT_STEP_CYC);
  // dead time grows with slower slew codes
  assign dead_cyc = 12'(`HCC_DEAD_BASE_CYC
                        + 32'(slew_eff) * `HCC_DEAD_STEP_CYC);

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      TRIP_LEVEL_SELECT_O <= `HCC_TLVL_RST;
      SLEW_SELECT_O       <= `HCC_SLEW_RST;
    end else begin
      TRIP_LEVEL_SELECT_O <= tlvl_eff;
      SLEW_SELECT_O       <= slew_eff;
    end
  end

  // ============================================================
  // Input and trip conditioning
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_in
      hcc_deglitch #(
        .DG_CYC (`HCC_DGL_CYC)
      ) u_in_dgl (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RST_N_I),
        .raw_i   (BRIDGE_IN_I[gi]),
        .clean_o (in_cln[gi])
      );

      hcc_deglitch #(
        .DG_CYC (`HCC_TRIP_FLT_CYC)
      ) u_trip_dgl (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RST_N_I),
        .raw_i   (OVER_TRIP_I[gi]),
        .clean_o (trip_cln[gi])
      );
    end
  endgenerate

  // ============================================================
  // Commanded bridge state
  // Output x drives high when its input is high, low when only the
  // other input is high, and floats when both inputs are low.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cmd_hi[i] = in_cln[i];
      if (in_cln[i]) begin
        tgt[i] = HB_HI;
      end else if (in_cln[1 - i]) begin
        tgt[i] = HB_LO;
      end else begin
        tgt[i] = HB_OFF;
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      fwd_q <= 2'h0;
    end else if (reg_act == 2'h0) begin
      fwd_q <= in_cln;
    end
  end

  assign reverse = (in_cln == ~fwd_q) && (in_cln[0] ^ in_cln[1]);
  // both high sides on while regulating, unless the inputs command the reverse direction
  assign force_hi = (reg_act != 2'h0) && !reverse;

  // ============================================================
  // Regulation channels and output stages
  generate
    for (gi = 0; gi < 2; gi++) begin : g_hb
      hcc_chop_if cif ();
      hcc_hb_t    app_q;
      hcc_hb_t    want;
      logic [11:0] dead_q;

      assign cif.en        = !mask_eff[gi];
      assign cif.trip      = trip_cln[gi];
      assign cif.drive_req = cmd_hi[gi];
      assign cif.off_cyc   = off_cyc;
      assign cif.blank_cyc = 12'(`HCC_BLANK_CYC);
      assign reg_act[gi]   = cif.regulating;

      hcc_chopper u_chop (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RST_N_I),
        .cif     (cif)
      );

      assign want = force_hi ? HB_HI : tgt[gi];

      always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
          app_q       <= HB_OFF;
          dead_q      <= 12'h000;
          HS_ON_O[gi] <= 1'b0;
          LS_ON_O[gi] <= 1'b0;
        end else if (want != app_q && app_q != HB_OFF) begin
          app_q       <= HB_OFF;
          dead_q      <= dead_cyc;
          HS_ON_O[gi] <= 1'b0;
          LS_ON_O[gi] <= 1'b0;
        end else if (want != app_q && dead_q == 12'h000) begin
          app_q       <= want;
          HS_ON_O[gi] <= (want == HB_HI);
          LS_ON_O[gi] <= (want == HB_LO);
        end else if (dead_q != 12'h000) begin
          dead_q <= dead_q - 12'h001;
        end
      end

      always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
          REGULATING_O[gi] <= 1'b0;
        end else begin
          REGULATING_O[gi] <= cif.regulating;
        end
      end
    end
  endgenerate
endmodule

`default_nettype wire

// >>> testbench/hcc_mcu_model.sv
// Controller model that drives the two bridge inputs
`default_nettype none

module hcc_mcu_model (
  input  wire logic       clk_i,  // Clock
  input  wire logic [1:0] cmd_i,  // Wanted input levels
  input  wire logic       go_i,   // Start a noise pulse
  output logic      [1:0] in_o    // Bridge inputs
);
  timeunit 1ns;
  timeprecision 1ps;
  // Starts idle so the inputs are clean from time zero
  logic [4:0] cnt_q = 5'h00;

  // ============================================================
  // Noise pulse, kept short of the input filter time
  // short noise pulse
  always_ff @(posedge clk_i) begin
    if (go_i) cnt_q <= 5'h0a;
    else if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
  end

  assign in_o = cmd_i ^ {1'b0, cnt_q != 5'h00 && cnt_q <= 5'h0a};
endmodule

`default_nettype wire

// >>> testbench/hcc_top_bench.sv
// Self-checking bench of the current chopper top
`default_nettype none

module hcc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        REF_CLK_I, RST_N_I, REG_WR_I, REG_RD_I, VARIANT_PIN_I;
  logic        REGULATION_DISABLE_STRAP_I, go;
  logic [7:0]  REG_ADDR_I;
  logic [31:0] REG_WDATA_I, REG_RDATA_O, d;
  logic [1:0]  BRIDGE_IN_I, OVER_TRIP_I, SLEW_STRAP_I, cmd;
  logic [1:0]  HS_ON_O, LS_ON_O, TRIP_LEVEL_SELECT_O, REGULATING_O;
  logic [2:0]  SLEW_SELECT_O;
  logic [2:0]  sx [3] = '{3'h0, 3'h3, 3'h7};
  logic [1:0]  sv [3] = '{2'h0, 2'h1, 2'h3};
  int          mismatches, check_count, n;

  hcc_top dut_u (.*);
  hcc_mcu_model mcu_u (.clk_i(REF_CLK_I), .cmd_i(cmd), .go_i(go),
    .in_o(BRIDGE_IN_I));

  initial begin
    REF_CLK_I = 1'b0;
    forever #20 REF_CLK_I = ~REF_CLK_I;
  end

  // ============================================================
  // Shared tasks
  task automatic cyc(input int k);
    repeat (k) @(posedge REF_CLK_I);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    REG_ADDR_I <= a;
    REG_WDATA_I <= v;
    REG_WR_I <= 1'b1;
    cyc(1);
    REG_WR_I <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    REG_ADDR_I <= a;
    REG_RD_I <= 1'b1;
    cyc(1);
    REG_RD_I <= 1'b0;
    v = REG_RDATA_O;
  endtask
  task automatic wreg(input logic v, input int mx);
    n = 0;
    while (REGULATING_O[0] !== v && n < mx) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic rst(input logic v, input logic s, input logic [1:0] sl);
    VARIANT_PIN_I <= v;
    REGULATION_DISABLE_STRAP_I <= s;
    SLEW_STRAP_I <= sl;
    RST_N_I <= 1'b0;
    cyc(6);
    RST_N_I <= 1'b1;
    cyc(30);
  endtask

  // ============================================================
  // Scenarios
  task automatic t_regs();
    rd(8'h00, d);
    chk(d, 32'h0000_0001);
    wr(8'h04, 32'h0000_ffff);
    rd(8'h04, d);
    chk(d, 32'h0000_0000);
    rd(8'h08, d);
    chk(d, 32'h0000_0000);
  endtask
  task automatic t_cfg();
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, (i << 6) | ((i & 3) << 2) | 1);
      cyc(3);
      chk(TRIP_LEVEL_SELECT_O, i & 3);
      chk(SLEW_SELECT_O, i);
    end
    wr(8'h00, 32'h0000_0001);
  endtask
  task automatic t_glitch();
    go <= 1'b1;
    cyc(1);
    go <= 1'b0;
    cyc(40);
    chk({HS_ON_O, LS_ON_O}, 4'h0);
    cmd <= 2'b01;
    n = 0;
    while (HS_ON_O[0] !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
    chk(n >= 26 && n <= 40, 1'b1);
    cyc(2);
    chk({HS_ON_O, LS_ON_O}, 4'b0110);
  endtask
  // Off period length is counted while the trip is held for hold cycles
  task automatic t_trip(input int t, input int hold, input bit rev,
                        input int len);
    wr(8'h00, t);
    cyc(150);
    OVER_TRIP_I[0] <= 1'b1;
    wreg(1'b1, 200);
    n = 0;
    while (REGULATING_O[0] === 1'b1 && n < 5000) begin
      cyc(1);
      n++;
      if (n == hold) OVER_TRIP_I[0] <= 1'b0;
      if (n == 60 && rev) cmd <= 2'b10;
      if (n == 200 && rev) chk({HS_ON_O, LS_ON_O}, 4'b1001);
    end
    chk(n, len);
    cmd <= 2'b01;
    cyc(80);
    chk({HS_ON_O, LS_ON_O}, 4'b0110);
  endtask
  task automatic t_mask();
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, m << 4);
      cyc(150);
      OVER_TRIP_I[0] <= 1'b1;
      wreg(1'b1, 300);
      chk(n < 300, !m[0]);
      chk(REGULATING_O[1], 1'b0);
      OVER_TRIP_I[0] <= 1'b0;
      wreg(1'b0, 1000);
    end
  endtask
  task automatic t_strap();
    for (int s = 0; s < 3; s++) begin
      rst(1'b1, 1'b1, sv[s]);
      chk(TRIP_LEVEL_SELECT_O, 2'h2);
      chk(SLEW_SELECT_O, sx[s]);
    end
    cyc(150);
    OVER_TRIP_I[0] <= 1'b1;
    wreg(1'b1, 300);
    chk(n, 300);
    OVER_TRIP_I[0] <= 1'b0;
    rst(1'b1, 1'b0, 2'h0);
    // Strapped off time stays 40 us whatever the field holds
    t_trip(0, 100, 0, 1000);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #2_000_000;
    mismatches++;
    summarize();
  end

  initial begin
    {REG_WR_I, REG_RD_I, go, OVER_TRIP_I, cmd} <= '0;
    REG_ADDR_I <= 8'h00;
    REG_WDATA_I <= 32'h0000_0000;
    rst(1'b0, 1'b0, 2'h0);
    t_regs();
    t_cfg();
    t_glitch();
    for (int t = 0; t < 4; t++) t_trip(t, 100, 0, (t + 1) * 500);
    t_trip(0, 600, 0, 1000);
    t_trip(0, 100, 1, 500);
    t_mask();
    t_strap();
    summarize();
  end
endmodule

`default_nettype wire

// >>> testbench/hcc_top_checker.sv
// Port-level checks of the current chopper top
`default_nettype none

module hcc_top_checker (
  input wire logic        REF_CLK_I,   // Clock
  input wire logic        RST_N_I,     // Reset
  input wire logic [7:0]  REG_ADDR_I,  // Address
  input wire logic [31:0] REG_WDATA_I, // Write data
  input wire logic        REG_WR_I,    // Write
  input wire logic        REG_RD_I,    // Read
  input wire logic [31:0] REG_RDATA_O, // Read data
  input wire logic [1:0]  BRIDGE_IN_I, // Inputs
  input wire logic [1:0]  OVER_TRIP_I, // Trip
  input wire logic        VARIANT_PIN_I, // Variant
  input wire logic        REGULATION_DISABLE_STRAP_I, // Strap
  input wire logic [1:0]  SLEW_STRAP_I, // Slew strap
  input wire logic [1:0]  HS_ON_O,     // High sides
  input wire logic [1:0]  LS_ON_O,     // Low sides
  input wire logic [1:0]  TRIP_LEVEL_SELECT_O, // Level
  input wire logic [2:0]  SLEW_SELECT_O, // Slew
  input wire logic [1:0]  REGULATING_O // Off period
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic [7:0] age_q;
  logic [3:0] up_q;
  logic [4:0] wr_q;

  // ============================================================
  // Helpers: drive age, time since reset, last control write
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I || $rose(HS_ON_O[0])) age_q <= 8'h00;
    else if (age_q != 8'hff) age_q <= age_q + 8'h01;
  end
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) up_q <= 4'h0;
    else if (up_q != 4'hf) up_q <= up_q + 4'h1;
  end
  always_ff @(posedge REF_CLK_I) begin
    if (REG_WR_I && REG_ADDR_I == 8'h00)
      wr_q <= {REG_WDATA_I[8:6], REG_WDATA_I[3:2]};
  end

  sequence ctrl_wr_s;
    REG_WR_I && REG_ADDR_I == 8'h00 && !VARIANT_PIN_I;
  endsequence
  sequence off_start_s;
    $rose(REGULATING_O[0]);
  endsequence

  // ============================================================
  // Assertions
  // no cross conduction
  no_shoot_a: assert property (!(|(HS_ON_O & LS_ON_O)))
    else $error("high and low side on together");
  // dead time after high side off
  dead_hs_a: assert property ($fell(HS_ON_O[0]) |-> !LS_ON_O[0] [*5])
    else $error("low side 1 on too soon");
  // dead time after low side off
  dead_ls_a: assert property ($fell(LS_ON_O[1]) |-> !HS_ON_O[1] [*5])
    else $error("high side 2 on too soon");
  rd_idle_a: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 32'h0000_0000)
    else $error("read data outside read slot");
  trip_cause_a: assert property (off_start_s |-> $past(OVER_TRIP_I[0], 2))
    else $error("off period without trip");
  force_hs_a: assert property (off_start_s |-> ##[0:40] HS_ON_O == 2'h3)
    else $error("high sides not forced");
  blank_a: assert property (off_start_s |-> age_q >= 8'h46)
    else $error("trip taken inside blanking");
  tlvl_wr_a: assert property (ctrl_wr_s |-> ##[1:3] TRIP_LEVEL_SELECT_O == wr_q[1:0])
    else $error("trip level not applied");
  slew_wr_a: assert property (ctrl_wr_s |-> ##[1:3] SLEW_SELECT_O == wr_q[4:2])
    else $error("slew code not applied");
  strap_cfg_a: assert property (up_q == 4'hf && VARIANT_PIN_I |->
    TRIP_LEVEL_SELECT_O == 2'h2 && SLEW_SELECT_O == (SLEW_STRAP_I == 2'h0 ?
    3'h0 : SLEW_STRAP_I == 2'h3 ? 3'h7 : 3'h3))
    else $error("strapped settings wrong");
endmodule

bind hcc_top hcc_top_checker chk_u (.*);

`default_nettype wire
